// file: accr_defines.svh
// register offsets, field positions and reset values of the channel calibration bank
`ifndef ACCR_DEFINES_SVH
`define ACCR_DEFINES_SVH
`define ACCR_ADDR_W 6
`define ACCR_CH3_OFS_LOW 6'h1A
`define ACCR_CH3_GAIN_HIGH 6'h1B
`define ACCR_CH3_GAIN_LOW 6'h1C
`define ACCR_CH4_CHANNEL_CONFIG 6'h1D
`define ACCR_CH4_OFS_HIGH 6'h1E
`define ACCR_CH4_OFS_LOW 6'h1F
`define ACCR_CH4_GAIN_HIGH 6'h20
`define ACCR_CH4_GAIN_LOW 6'h21
`define ACCR_PHASE_MSB 15
`define ACCR_PHASE_LSB 6
`define ACCR_DCOFF_BIT 2
`define ACCR_MUX_MSB 1
`define ACCR_MUX_LSB 0
`define ACCR_GAIN_HIGH_RST 16'h8000
`define ACCR_GAIN_LOW_RST 8'h00
`define ACCR_OFS_RST 16'h0000
`define ACCR_CFG_RST 16'h0000
`endif

// file: accr_pkg.sv
// types of the channel calibration bank
package accr_pkg;
  typedef enum logic [1:0] {
    ACCR_IN_PINS = 2'h0,
    ACCR_IN_SHORT = 2'h1,
    ACCR_IN_POS_TEST = 2'h2,
    ACCR_IN_NEG_TEST = 2'h3
  } accr_input_t;
  typedef struct packed {
    logic signed [9:0] phaseDelay;
    logic dcBlockOff;
    accr_input_t inputSelect;
  } accr_chan_cfg_t;
  typedef struct packed {
    logic signed [23:0] offsetWord;
    logic [23:0] gainWord;
  } accr_chan_cal_t;
endpackage

// file: accr_cal_regs.sv
// register bank: channel 3 calibration tail and channel 4 configuration/calibration
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ns
`include "accr_defines.svh"
module accr_cal_regs
  import accr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [`ACCR_ADDR_W-1:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [15:0] regRdData,
  // global dc filter setting for channel 4's lane
  input wire logic globalDcFilterSetting,
  // values toward the filter path
  output logic [7:0] ch3OffsetLowByte,
  output logic [23:0] ch3GainWord,
  output accr_chan_cfg_t ch4Config,
  output accr_chan_cal_t ch4Cal,
  output logic ch4DcBlockActive
);
  logic [7:0] ch3OfsLow_q;
  logic [15:0] ch3GainHigh_q;
  logic [7:0] ch3GainLow_q;
  logic [9:0] ch4Phase_q;
  logic ch4DcOff_q;
  logic [1:0] ch4Mux_q;
  logic [15:0] ch4OfsHigh_q;
  logic [7:0] ch4OfsLow_q;
  logic [15:0] ch4GainHigh_q;
  logic [7:0] ch4GainLow_q;
  logic [15:0] rdData_d;
  logic [15:0] rdData_q;
  logic dcActive_q;

  // channel 3 registers
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ch3OfsLow_q <= 8'h00;
      ch3GainHigh_q <= `ACCR_GAIN_HIGH_RST;
      ch3GainLow_q <= `ACCR_GAIN_LOW_RST;
    end else if (regWrStb) begin
      if (regAddr == `ACCR_CH3_OFS_LOW) begin
        ch3OfsLow_q <= regWrData[15:8];
      end
      if (regAddr == `ACCR_CH3_GAIN_HIGH) begin
        ch3GainHigh_q <= regWrData;
      end
      if (regAddr == `ACCR_CH3_GAIN_LOW) begin
        ch3GainLow_q <= regWrData[15:8];
      end
    end
  end

  // channel 4 configuration
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ch4Phase_q <= 10'h000;
      ch4DcOff_q <= 1'b0;
      ch4Mux_q <= 2'h0;
    end else if (regWrStb && regAddr == `ACCR_CH4_CHANNEL_CONFIG) begin
      ch4Phase_q <= regWrData[`ACCR_PHASE_MSB:`ACCR_PHASE_LSB];
      ch4DcOff_q <= regWrData[`ACCR_DCOFF_BIT];
      ch4Mux_q <= regWrData[`ACCR_MUX_MSB:`ACCR_MUX_LSB];
    end
  end

  // channel 4 calibration
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ch4OfsHigh_q <= `ACCR_OFS_RST;
      ch4OfsLow_q <= 8'h00;
      ch4GainHigh_q <= `ACCR_GAIN_HIGH_RST;
      ch4GainLow_q <= `ACCR_GAIN_LOW_RST;
    end else if (regWrStb) begin
      if (regAddr == `ACCR_CH4_OFS_HIGH) begin
        ch4OfsHigh_q <= regWrData;
      end
      if (regAddr == `ACCR_CH4_OFS_LOW) begin
        ch4OfsLow_q <= regWrData[15:8];
      end
      if (regAddr == `ACCR_CH4_GAIN_HIGH) begin
        ch4GainHigh_q <= regWrData;
      end
      if (regAddr == `ACCR_CH4_GAIN_LOW) begin
        ch4GainLow_q <= regWrData[15:8];
      end
    end
  end

  // read mux; reserved low bytes and unmapped addresses return zero
  always_comb begin
    rdData_d = 16'h0000;
    unique case (regAddr)
      `ACCR_CH3_OFS_LOW: rdData_d = {ch3OfsLow_q, 8'h00};
      `ACCR_CH3_GAIN_HIGH: rdData_d = ch3GainHigh_q;
      `ACCR_CH3_GAIN_LOW: rdData_d = {ch3GainLow_q, 8'h00};
      `ACCR_CH4_CHANNEL_CONFIG: rdData_d = {ch4Phase_q, 3'h0, ch4DcOff_q, ch4Mux_q};
      `ACCR_CH4_OFS_HIGH: rdData_d = ch4OfsHigh_q;
      `ACCR_CH4_OFS_LOW: rdData_d = {ch4OfsLow_q, 8'h00};
      `ACCR_CH4_GAIN_HIGH: rdData_d = ch4GainHigh_q;
      `ACCR_CH4_GAIN_LOW: rdData_d = {ch4GainLow_q, 8'h00};
      default: rdData_d = 16'h0000;
    endcase
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdData_q <= 16'h0000;
    end else if (regRdStb) begin
      rdData_q <= rdData_d;
    end else begin
      rdData_q <= 16'h0000;
    end
  end

  // per-channel disable overrides the global setting, never enables on its own
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dcActive_q <= 1'b0;
    end else begin
      dcActive_q <= globalDcFilterSetting && !ch4DcOff_q;
    end
  end

  assign regRdData = rdData_q;
  assign ch3OffsetLowByte = ch3OfsLow_q;
  // unsigned fraction, 800000h is unity
  assign ch3GainWord = {ch3GainHigh_q, ch3GainLow_q};
  assign ch4Config = '{phaseDelay: ch4Phase_q, dcBlockOff: ch4DcOff_q,
                       inputSelect: accr_input_t'(ch4Mux_q)};
  assign ch4Cal = '{offsetWord: {ch4OfsHigh_q, ch4OfsLow_q},
                    gainWord: {ch4GainHigh_q, ch4GainLow_q}};
  assign ch4DcBlockActive = dcActive_q;
endmodule // accr_cal_regs

// file: accr_chk.sv
// assertions on the ports of the channel calibration register bank
`timescale 1ns/1ns
module accr_chk
  import accr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // register port
  input wire logic [5:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [15:0] regRdData,
  // filter side
  input wire logic globalDcFilterSetting,
  input wire logic [23:0] ch3GainWord,
  input wire accr_chan_cfg_t ch4Config,
  input wire accr_chan_cal_t ch4Cal,
  input wire logic ch4DcBlockActive
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  rd_idle_a: assert property (!regRdStb |=> regRdData == 16'h0000)
    else $error("read data not zero outside a read");
  ch3_gain_a: assert property (regWrStb && regAddr == 6'h1B |=> ch3GainWord[23:8] == $past(regWrData))
    else $error("ch3 gain high not stored");
  gain_hi_a: assert property (regWrStb && regAddr == 6'h20 |=> ch4Cal.gainWord[23:8] == $past(regWrData))
    else $error("ch4 gain high not stored");
  ofs_hi_a: assert property (regWrStb && regAddr == 6'h1E |=> ch4Cal.offsetWord[23:8] == $past(regWrData))
    else $error("ch4 offset high not stored");
  ofs_lo_a: assert property (regWrStb && regAddr == 6'h1F |=> ch4Cal.offsetWord[7:0] == $past(regWrData[15:8]))
    else $error("ch4 offset low not stored");
  cfg_wr_a: assert property (regWrStb && regAddr == 6'h1D |=> ch4Config == {$past(regWrData[15:6]), $past(regWrData[2:0])})
    else $error("ch4 config fields not stored");
  cfg_rsvd_a: assert property (regRdStb && regAddr == 6'h1D |=> regRdData[5:3] == 3'h0)
    else $error("config reserved bits not zero");
  dc_lane_a: assert property ($past(rst_n) |-> ch4DcBlockActive == $past(globalDcFilterSetting && !ch4Config.dcBlockOff))
    else $error("dc block state wrong");
endmodule // accr_chk

// file: accr_tb.sv
// self-checking bench for the channel calibration register bank
`timescale 1ns/1ns
module testbench import accr_pkg::*;;
  logic clock = 0, rst_n = 0, regWrStb = 0, regRdStb = 0, globalDcFilterSetting = 0, ch4DcBlockActive;
  logic [5:0] regAddr = 6'h00;
  logic [15:0] regWrData = 16'h0000, regRdData;
  logic [7:0] ch3OffsetLowByte;
  logic [23:0] ch3GainWord;
  accr_chan_cfg_t ch4Config;
  accr_chan_cal_t ch4Cal;
  int mismatches = 0, tests_run = 0;
  accr_cal_regs u_dut(.clock, .rst_n, .regAddr, .regWrData, .regWrStb, .regRdStb, .regRdData,
    .globalDcFilterSetting, .ch3OffsetLowByte, .ch3GainWord, .ch4Config, .ch4Cal, .ch4DcBlockActive);
  initial forever #10 clock = ~clock;
  task chk(input bit ok, input string m);
    tests_run++;
    if (!ok) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  task wr(input int a, input logic [15:0] d);
    @(posedge clock);
    regAddr <= 6'(a);
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clock);
    regWrStb <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe, so look there
  task rd(input int a, input logic [15:0] e);
    @(posedge clock);
    regAddr <= 6'(a);
    regRdStb <= 1'b1;
    @(posedge clock);
    regRdStb <= 1'b0;
    #1 chk(regRdData === e, "read data");
  endtask
  task t_reset;
    for (int a = 'h1A; a <= 'h21; a++) rd(a, (a == 'h1B || a == 'h20) ? 16'h8000 : 16'h0000);
    chk(ch4Cal.gainWord === 24'h800000, "unity gain");
    chk(ch4DcBlockActive === 1'b0, "dc block idle");
    $display("reset test done");
  endtask
  task t_ones;
    for (int a = 'h1A; a <= 'h21; a++) wr(a, 16'hFFFF);
    wr('h3F, 16'h1234);
    for (int a = 'h1A; a <= 'h21; a++) rd(a, a inside {'h1A, 'h1C, 'h1F, 'h21} ? 16'hFF00 : a == 'h1D ? 16'hFFC7 : 16'hFFFF);
    rd('h3F, 16'h0000);
    chk(ch4Cal === {24'hFFFFFF, 24'hFFFFFF} && ch3GainWord === 24'hFFFFFF, "words");
    chk(ch3OffsetLowByte === 8'hFF, "ch3 offset low byte");
    $display("all-ones test done");
  endtask
  task t_cfg;
    @(posedge clock);
    globalDcFilterSetting <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      wr('h1D, {10'h201, 3'h7, m[0], m[1:0]});
      @(posedge clock);
      #1 chk(ch4Config === {10'h201, m[0], m[1:0]} && ch4DcBlockActive === !m[0], "config");
      rd('h1D, {10'h201, 3'h0, m[0], m[1:0]});
    end
    $display("config test done");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_ones();
    t_cfg();
    tally_and_finish();
  end
  // the tests need under a hundred cycles; this cuts a hang short
  initial begin
    #100000;
    mismatches++;
    tally_and_finish();
  end
endmodule // testbench
bind accr_cal_regs accr_chk u_chk(.clock, .rst_n, .regAddr, .regWrData, .regWrStb, .regRdStb,
  .regRdData, .globalDcFilterSetting, .ch3GainWord, .ch4Config, .ch4Cal, .ch4DcBlockActive);
